//--- core/hdlc_rx_fifo_ctrl.sv
// Receive buffer, block threshold and host handshake of one HDLC
// channel. Assumes the deframer delivers stored bytes and one
// frame-end strobe, and a host on an Avalon-MM port.
//
// Contract
// - Cyclic buffer, 64 D or 128 B
// - D block size codes 32/16/8/4
// - B block size codes 64/32/16/8
// - Reset block size 32 D, 64 B
// - Pool-full when block ready, frame longer
// - Message-end when whole frame stored
// - New frame into full buffer dropped, flagged
// - Release frees block, clears frame counter; code keeps it, count regs show next entry
// - Receiver reset empties buffer, keeps irq flags
// - Twelve-bit frame count in two registers
// - Count overflow bit beyond 4095 bytes
// - Low count bits give last block bytes
// - Zero last count means full block
// - Block size reloaded on release, reset
// - Status byte always follows frame data
// - Queued events shown right after release
// - Lost bytes set data overflow flag
// - Reads past valid data repeat last
// - Release discards unread bytes too
// - Reads without event keep contents intact
// - Status byte: crc, valid, abort, overflow
`timescale 1ns/1ps
`default_nettype none

module hdlc_rx_fifo_ctrl #(
  parameter int DEPTH   = hdlc_rx_pkg::DCH_DEPTH,
  parameter bit IS_BCH  = 1'b0,
  parameter int QDEPTH  = 16
) (
  input  wire logic                     clock,       // System clock
  input  wire logic                     rstn,        // Async reset
  input  wire logic [4:0]               address,     // Byte address
  input  wire logic                     read,        // Read request
  input  wire logic                     write,       // Write request
  input  wire logic [31:0]              writedata,   // Write data
  output logic      [31:0]              readdata,    // Read data
  output logic                          waitrequest, // Stall
  input  wire hdlc_rx_pkg::rx_link_t    rxLink       // Deframer
);

  localparam int AW = $clog2(DEPTH);
  localparam int QW = $clog2(QDEPTH);

  // ----------------------------------------------------------------
  // Register map as seen by the host
  // ----------------------------------------------------------------
  // Data    : next stored byte; the read pointer moves only inside
  //           the block now offered, or the stored bytes while none is, so over-reads repeat the last
  // Events  : bit 0 pool full, bit 1 message end, bit 2 frame lost;
  //           a read clears what it returned, a new set still wins
  // Command : bit 0 release block, bit 1 receiver reset (wins)
  // Mode    : block size code, taken over on release or reset
  // Count   : low and high halves of the head entry's frame count;
  //           both read zero while nothing is offered
  //
  // Entries are queued as blocks complete, so the host may lag by
  // up to QDEPTH blocks; beyond that new entries are lost and the
  // host has to recover with a receiver reset.
  // Pointers carry one extra bit so full and empty stay distinct.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hdlc_rx_pkg::rx_state_t st;
    logic [AW:0]   wp;
    logic [AW:0]   rel;
    logic [AW:0]   rdp;
    logic [QW:0]   qHead;
    logic [QW:0]   qTail;
    logic          shown;
    logic [2:0]    irq;
    logic [1:0]    rx_block_size_field;
    logic [1:0]    actRfbs;
    logic [7:0]    blkCnt;
    logic [11:0]   frmCnt;
    logic          frmOv;
    logic          dovf;
    logic          ack;
    logic [7:0]    rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [7:0]                  mem [DEPTH];
  hdlc_rx_pkg::queue_entry_t   queue [QDEPTH];

  logic                        memWe;
  logic [AW-1:0]               memAddr;
  logic [7:0]                  memData;
  logic                        qWe;
  hdlc_rx_pkg::queue_entry_t   qData;

  // Block size from the size code and channel kind
  function automatic logic [7:0] blkSize(input logic [1:0] code);
    logic [7:0] base;
    base = IS_BCH ? hdlc_rx_pkg::BCH_BASE_BLK
                  : hdlc_rx_pkg::DCH_BASE_BLK;
    return base >> code;
  endfunction

  // Bus access completing this cycle at a given register
  function automatic logic busDone(input logic       ack,
                                   input logic       req,
                                   input logic [4:0] adr,
                                   input logic [4:0] want);
    return ack && req && (adr == want);
  endfunction

  // Pointer advance by a block length
  function automatic logic [AW:0] ptrAdv(input logic [AW:0] p,
                                         input logic [7:0]  n);
    return p + (AW+1)'(n);
  endfunction

  logic [AW:0]                 used;
  logic [AW:0]                 avail;
  logic [AW:0]                 rdOff;
  logic [QW:0]                 qCount;
  logic                        qEmpty;
  logic                        qFull;
  logic                        room;
  logic [7:0]                  thr;
  hdlc_rx_pkg::queue_entry_t   head;
  logic [7:0]                  stat;
  logic [7:0]                  muxData;

  assign used   = s_reg.wp - s_reg.rel;
  assign qCount = s_reg.qTail - s_reg.qHead;
  assign qEmpty = (qCount == '0);
  assign qFull  = (qCount == (QW+1)'(QDEPTH));
  // One slot is kept back so the status byte always fits
  assign room   = (used < (AW+1)'(DEPTH - 1));
  assign thr    = blkSize(s_reg.actRfbs);
  assign head   = queue[s_reg.qHead[QW-1:0]];
  assign avail  = qEmpty ? used : (AW+1)'(head.len);
  assign rdOff  = s_reg.rdp - s_reg.rel;

  assign waitrequest = (read | write) & ~s_reg.ack;
  assign readdata    = {24'h000000, s_reg.rdata};

  // ----------------------------------------------------------------
  // Status byte appended after the last data byte
  // ----------------------------------------------------------------
  // Built every cycle; only written when the frame end arrives
  always_comb begin
    stat                           = 8'h00;
    stat[hdlc_rx_pkg::STAT_VALID]  = rxLink.crcOk & ~rxLink.abort;
    stat[hdlc_rx_pkg::STAT_DOVF]   = s_reg.dovf;
    stat[hdlc_rx_pkg::STAT_CRC_OK] = rxLink.crcOk;
    stat[hdlc_rx_pkg::STAT_ABORT]  = rxLink.abort;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    muxData = 8'h00;
    case (address)
      hdlc_rx_pkg::ADDR_DATA: muxData = mem[s_reg.rdp[AW-1:0]];
      hdlc_rx_pkg::ADDR_IRQ:  muxData = {5'h00, s_reg.irq};
      hdlc_rx_pkg::ADDR_MODE: muxData = {6'h00, s_reg.rx_block_size_field};
      hdlc_rx_pkg::ADDR_CNTL: begin
        if (!qEmpty) begin
          muxData = head.count[7:0];
        end
      end
      hdlc_rx_pkg::ADDR_CNTH: begin
        if (!qEmpty) begin
          muxData = {3'h0, head.ov, head.count[11:8]};
        end
      end
      default: muxData = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next  = s_reg;
    memWe   = 1'b0;
    memAddr = s_reg.wp[AW-1:0];
    memData = rxLink.data;
    qWe     = 1'b0;
    qData   = '0;

    // --------------------------------------------------------------
    // Bus handshake
    // --------------------------------------------------------------
    // One wait state: the answer is captured a cycle ahead, so the
    // read mux never sits on the path to readdata
    if (s_reg.ack) begin
      s_next.ack = 1'b0;
    end else if (read | write) begin
      s_next.ack   = 1'b1;
      s_next.rdata = muxData;
    end

    // Bus side effects, before hardware sets so sets win
    if (s_reg.ack && read) begin
      if (address == hdlc_rx_pkg::ADDR_IRQ) begin
        s_next.irq = s_reg.irq & ~s_reg.rdata[2:0];
      end
      if (address == hdlc_rx_pkg::ADDR_DATA &&
          rdOff + 1'b1 < avail) begin
        s_next.rdp = s_reg.rdp + 1'b1;
      end
    end
    if (busDone(s_reg.ack, write, address, hdlc_rx_pkg::ADDR_MODE)) begin
      s_next.rx_block_size_field = writedata[1:0];
    end

    // --------------------------------------------------------------
    // Frame reception
    // --------------------------------------------------------------
    // No back pressure toward the deframer: a byte without room is
    // lost and only remembered in the status byte; a frame whose
    // first byte finds no room is dropped whole.
    case (s_reg.st)
      hdlc_rx_pkg::ST_IDLE: begin
        if (rxLink.byteValid) begin
          if (room) begin
            memWe         = 1'b1;
            s_next.wp     = s_reg.wp + 1'b1;
            s_next.frmCnt = 12'h001;
            s_next.blkCnt = 8'h01;
            s_next.frmOv  = 1'b0;
            s_next.dovf   = 1'b0;
            s_next.st     = hdlc_rx_pkg::ST_RECV;
          end else begin
            s_next.irq[hdlc_rx_pkg::IRQ_FRAME_OVF] = 1'b1;
            s_next.st = hdlc_rx_pkg::ST_DROP;
          end
        end
      end
      hdlc_rx_pkg::ST_RECV: begin
        if (rxLink.frameEnd) begin
          memWe       = 1'b1;
          memData     = stat;
          s_next.wp   = s_reg.wp + 1'b1;
          qWe         = ~qFull;
          qData.isEnd = 1'b1;
          qData.count = s_reg.frmCnt + 1'b1;
          qData.ov    = s_reg.frmOv | (&s_reg.frmCnt);
          qData.len   = s_reg.blkCnt + 1'b1;
          s_next.st   = hdlc_rx_pkg::ST_IDLE;
        end else if (rxLink.byteValid) begin
          if (room) begin
            memWe         = 1'b1;
            s_next.wp     = s_reg.wp + 1'b1;
            s_next.frmCnt = s_reg.frmCnt + 1'b1;
            s_next.frmOv  = s_reg.frmOv | (&s_reg.frmCnt);
            s_next.blkCnt = s_reg.blkCnt + 1'b1;
            // A full block of data queues a pool-full entry and restarts the block count
            if (s_reg.blkCnt + 1'b1 == thr) begin
              qWe           = ~qFull;
              qData.isEnd   = 1'b0;
              qData.count   = s_reg.frmCnt + 1'b1;
              qData.ov      = s_next.frmOv;
              qData.len     = thr;
              s_next.blkCnt = 8'h00;
            end
          end else begin
            s_next.dovf = 1'b1;
          end
        end
      end
      hdlc_rx_pkg::ST_DROP: begin
        if (rxLink.frameEnd) begin
          s_next.st = hdlc_rx_pkg::ST_IDLE;
        end
      end
      default: s_next.st = hdlc_rx_pkg::ST_IDLE;
    endcase
    if (qWe) begin
      s_next.qTail = s_reg.qTail + 1'b1;
    end

    // --------------------------------------------------------------
    // Event presentation
    // --------------------------------------------------------------
    // Present the oldest queued block to the host
    if (!qEmpty && !s_reg.shown) begin
      s_next.shown = 1'b1;
      if (head.isEnd) begin
        s_next.irq[hdlc_rx_pkg::IRQ_MSG_END] = 1'b1;
      end else begin
        s_next.irq[hdlc_rx_pkg::IRQ_POOL_FULL] = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // Commands
    // --------------------------------------------------------------
    // Last in the process so a receiver reset overrides any write
    // or queue entry of the same cycle
    if (busDone(s_reg.ack, write, address, hdlc_rx_pkg::ADDR_CMD)) begin
      if (writedata[hdlc_rx_pkg::CMD_RX_RESET]) begin
        s_next.wp      = '0;
        s_next.rel     = '0;
        s_next.rdp     = '0;
        s_next.qHead   = '0;
        s_next.qTail   = '0;
        s_next.shown   = 1'b0;
        s_next.st      = hdlc_rx_pkg::ST_IDLE;
        s_next.actRfbs = s_reg.rx_block_size_field;
        qWe            = 1'b0;
        memWe          = 1'b0;
      end else if (writedata[hdlc_rx_pkg::CMD_RELEASE]) begin
        s_next.actRfbs = s_reg.rx_block_size_field;
        if (!qEmpty) begin
          s_next.rel   = ptrAdv(s_reg.rel, head.len);
          s_next.rdp   = ptrAdv(s_reg.rel, head.len);
          s_next.qHead = s_reg.qHead + 1'b1;
          s_next.shown = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Arrays carry no reset; pointers and queue indices guard them
  always_ff @(posedge clock) begin
    if (memWe) begin
      mem[memAddr] <= memData;
    end
    if (qWe) begin
      queue[s_reg.qTail[QW-1:0]] <= qData;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg         <= '0;
      s_reg.st      <= hdlc_rx_pkg::ST_IDLE;
      s_reg.rx_block_size_field    <= hdlc_rx_pkg::RX_BLOCK_SIZE_FIELD_RESET;
      s_reg.actRfbs <= hdlc_rx_pkg::RX_BLOCK_SIZE_FIELD_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

`default_nettype wire

//--- common/hdlc_rx_pkg.sv
// Constants and types shared by the receive buffer controller.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package hdlc_rx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W     = 5;
  localparam logic [4:0] ADDR_DATA  = 5'h00;
  localparam logic [4:0] ADDR_IRQ   = 5'h04;
  localparam logic [4:0] ADDR_CMD   = 5'h08;
  localparam logic [4:0] ADDR_MODE  = 5'h0c;
  localparam logic [4:0] ADDR_CNTL  = 5'h10;
  localparam logic [4:0] ADDR_CNTH  = 5'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         IRQ_POOL_FULL = 0;
  localparam int         IRQ_MSG_END   = 1;
  localparam int         IRQ_FRAME_OVF = 2;
  localparam int         CMD_RELEASE   = 0;
  localparam int         CMD_RX_RESET  = 1;
  localparam int         STAT_VALID    = 7;
  localparam int         STAT_DOVF     = 6;
  localparam int         STAT_CRC_OK   = 5;
  localparam int         STAT_ABORT    = 4;
  localparam int         CNT_OV_BIT    = 4;
  localparam logic [1:0] RX_BLOCK_SIZE_FIELD_RESET    = 2'h0;
  localparam logic [7:0] DCH_BASE_BLK  = 8'h20;
  localparam logic [7:0] BCH_BASE_BLK  = 8'h40;
  localparam int         DCH_DEPTH     = 64;
  localparam int         BCH_DEPTH     = 128;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_DROP} rx_state_t;

  typedef struct packed {
    logic       byteValid;
    logic [7:0] data;
    logic       frameEnd;
    logic       crcOk;
    logic       abort;
  } rx_link_t;

  typedef struct packed {
    logic        isEnd;
    logic        ov;
    logic [11:0] count;
    logic [7:0]  len;
  } queue_entry_t;

endpackage

//--- bench/hdlc_rx_fifo_ctrl_asserts.sv
// Port-level checks of the receive buffer controller.
// Assumes the bench master keeps the bus handshake; bound below.
`timescale 1ns/1ps
`default_nettype none
module hdlc_rx_fifo_ctrl_asserts (
  input wire logic                  clock,       // Clock
  input wire logic                  rstn,        // Reset
  input wire logic [4:0]            address,     // Address
  input wire logic                  read,        // Read
  input wire logic                  write,       // Write
  input wire logic [31:0]           writedata,   // Write data
  input wire logic [31:0]           readdata,    // Read data
  input wire logic                  waitrequest, // Stall
  input wire hdlc_rx_pkg::rx_link_t rxLink       // Link
);
  logic modeSet_reg;
  logic rdDone;
  logic [4:0] a;
  assign rdDone = read && !waitrequest;
  assign a = address;
  // Mode reads zero until software first writes it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) modeSet_reg <= 1'b0;
    else if (write && a == hdlc_rx_pkg::ADDR_MODE) modeSet_reg <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_rd_wait;
    $rose(read) |-> waitrequest ##1 !waitrequest;
  endproperty
  property p_wr_wait;
    $rose(write) |-> waitrequest ##1 !waitrequest;
  endproperty
  property p_byte_wide;
    rdDone |-> readdata[31:8] == 24'h0;
  endproperty
  property p_irq_bits;
    rdDone && a == hdlc_rx_pkg::ADDR_IRQ |-> readdata[7:3] == 5'h0;
  endproperty
  property p_cnt_high;
    rdDone && a == hdlc_rx_pkg::ADDR_CNTH |-> readdata[7:5] == 3'h0;
  endproperty
  property p_mode_bits;
    rdDone && a == hdlc_rx_pkg::ADDR_MODE |-> readdata[7:2] == 6'h0;
  endproperty
  property p_mode_rst;
    rdDone && a == hdlc_rx_pkg::ADDR_MODE && !modeSet_reg |-> readdata == 0;
  endproperty
  property p_unmapped;
    rdDone && a > hdlc_rx_pkg::ADDR_CNTH |-> readdata == 32'h0;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  a_wr_wait: assert property (p_wr_wait) else $error("write wait");
  a_byte_wide: assert property (p_byte_wide) else $error("wide");
  a_irq_bits: assert property (p_irq_bits) else $error("irq bits");
  a_cnt_high: assert property (p_cnt_high) else $error("count hi");
  a_mode_bits: assert property (p_mode_bits) else $error("mode");
  a_mode_rst: assert property (p_mode_rst) else $error("mode rst");
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  c_pool: cover property (rdDone && a == 5'h04 && readdata[0]);
  c_end: cover property (rdDone && a == 5'h04 && readdata[1]);
  c_ovf: cover property (rdDone && a == 5'h04 && readdata[2]);
endmodule
bind hdlc_rx_fifo_ctrl hdlc_rx_fifo_ctrl_asserts u_chk (
  .clock(clock), .rstn(rstn), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .rxLink(rxLink));
`default_nettype wire

//--- bench/hdlc_rx_link_model.sv
// Deframer stand-in: bytes back to back, then one frame-end strobe.
// Assumes the caller waits for the task before the next frame.
`timescale 1ns/1ps
`default_nettype none
module hdlc_rx_link_model (
  input wire logic               clock, // Clock
  output var hdlc_rx_pkg::rx_link_t link // To controller
);
  initial link = '0;
  task automatic send_frame(input int len, input logic [7:0] base,
                            input logic crc, input logic ab);
    for (int i = 0; i < len; i++) begin
      @(posedge clock);
      link <= '{1'b1, base + 8'(i), 1'b0, 1'b0, 1'b0};
    end
    // Idle data inverted so a stale byte is never mistaken for a new one
    @(posedge clock);
    link <= '{1'b0, ~link.data, 1'b1, crc, ab};
    @(posedge clock);
    link <= '{1'b0, ~link.data, 1'b0, ~crc, ~ab};
  endtask
endmodule
`default_nettype wire

//--- bench/hdlc_receive_fifo_control_tb_top.sv
// Random and corner-case receive traffic with host block handshake.
// Assumes the D-channel build and one wait state per bus access.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  n_fail++; $display("Error %0t: got %h want %h", $time, got, exp); end end
module hdlc_receive_fifo_control_tb_top;
  logic                  clock = 1'b0;
  logic                  rstn = 1'b0;
  logic [4:0]            address = '0;
  logic                  read = 1'b0;
  logic                  write = 1'b0;
  logic [31:0]           writedata = '0;
  logic [31:0]           readdata;
  logic                  waitrequest;
  hdlc_rx_pkg::rx_link_t rxLink;
  logic [31:0]           seed = 32'h9947;
  logic [31:0]           rd;
  logic [7:0]            base;
  logic                  c;
  logic                  ab;
  int                    len;
  int                    n_fail = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  always #25 clock = ~clock;
  hdlc_rx_fifo_ctrl #(.DEPTH(64), .IS_BCH(1'b0), .QDEPTH(16)) u_dut (
    .clock(clock), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxLink(rxLink));
  hdlc_rx_link_model u_link (.clock(clock), .link(rxLink));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    chk(hdlc_rx_pkg::ADDR_MODE, 32'h0);
    chk(hdlc_rx_pkg::ADDR_CNTL, 32'h0);
    chk(5'h1c, 32'h0);
    bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h1);
    chk(hdlc_rx_pkg::ADDR_CNTL, 32'h0);
    $display("reset test done");
    repeat (4) begin
      len = 1 + int'(rnd() % 20);
      base = 8'(rnd());
      c = rnd() % 2 == 0;
      ab = rnd() % 4 == 0;
      u_link.send_frame(len, base, c, ab);
      chk(hdlc_rx_pkg::ADDR_IRQ, 32'h2);
      chk(hdlc_rx_pkg::ADDR_CNTL, len + 1);
      for (int i = 0; i < len; i++) chk(5'h00, 8'(base + i));
      chk(5'h00, {c & ~ab, 1'b0, c, ab, 4'h0});
      chk(5'h00, {c & ~ab, 1'b0, c, ab, 4'h0});
      bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h1);
      chk(hdlc_rx_pkg::ADDR_CNTL, 32'h0);
    end
    $display("short frame test done");
    bus(1'b1, hdlc_rx_pkg::ADDR_MODE, 32'h3);
    bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h2);
    u_link.send_frame(9, 8'h10, 1'b1, 1'b0);
    chk(hdlc_rx_pkg::ADDR_IRQ, 32'h1);
    chk(5'h00, 32'h10);
    bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h1);
    chk(hdlc_rx_pkg::ADDR_IRQ, 32'h1);
    chk(5'h00, 32'h14);
    bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h1);
    chk(hdlc_rx_pkg::ADDR_IRQ, 32'h2);
    chk(hdlc_rx_pkg::ADDR_CNTL, 32'ha);
    chk(5'h00, 32'h18);
    bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h1);
    $display("block test done");
    bus(1'b1, hdlc_rx_pkg::ADDR_MODE, 32'h0);
    bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h2);
    u_link.send_frame(70, 8'h40, 1'b1, 1'b0);
    u_link.send_frame(5, 8'h00, 1'b1, 1'b0);
    bus(1'b1, hdlc_rx_pkg::ADDR_CMD, 32'h2);
    chk(hdlc_rx_pkg::ADDR_IRQ, 32'h5);
    chk(hdlc_rx_pkg::ADDR_IRQ, 32'h0);
    chk(hdlc_rx_pkg::ADDR_CNTL, 32'h0);
    $display("overflow test done");
    final_report();
  end
endmodule
`default_nettype wire
